// ---- hdl/lfw_defines.svh ----
// constants of the low-frequency wake-up telegram receiver
// assumes a 100 MHz clock and an apb register port with 32-bit data
`ifndef LFW_DEFINES_SVH
`define LFW_DEFINES_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define LFW_OFS_POWER_CTRL 12'h000
`define LFW_OFS_LISTEN_ON 12'h004
`define LFW_OFS_LISTEN_OFF_HIGH 12'h008
`define LFW_OFS_LISTEN_OFF_LOW 12'h00c
`define LFW_OFS_WAKE_PAT_HIGH 12'h010
`define LFW_OFS_WAKE_PAT_LOW 12'h014
`define LFW_OFS_MAX_WORDS 12'h018
`define LFW_OFS_RX_HIGH 12'h01c
`define LFW_OFS_RX_LOW 12'h020
`define LFW_OFS_IRQ_FLAGS 12'h024
`define LFW_OFS_IRQ_MASK 12'h028
`define LFW_OFS_STATE 12'h02c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LFW_CTRL_LISTEN 0
`define LFW_CTRL_CARRIER_MODE 1
`define LFW_CTRL_WAKE_EN 4
`define LFW_CTRL_WAKE_RELEASE 7
`define LFW_FLAG_WAKE 0
`define LFW_FLAG_END 1
`define LFW_FLAG_DISCARD 2
`define LFW_FLAG_RX_WORD 5

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LFW_RST_CTRL 8'h00
`define LFW_RST_ON_COUNT 8'h04
`define LFW_RST_OFF_COUNT 16'h0010
`define LFW_RST_MAX_WORDS 8'h04

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LFW_CLK_PERIOD_NS 10
`define LFW_TICK_US 1000
`define LFW_TICK_CYCLES ((`LFW_TICK_US * 1000) / `LFW_CLK_PERIOD_NS)
`define LFW_PREAMBLE_MIN_BITS 6'd8
`define LFW_SYNC_SYMBOLS 2'd2

`endif

// ---- hdl/lfw_pkg.sv ----
// types shared by the wake-up telegram receiver
// assumes lfw_defines.svh holds the numeric constants
package lfw_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OFF,
        ST_ON,
        ST_SYNC,
        ST_RX
    } lfw_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lfw_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lfw_apb_rsp_t;

    typedef struct packed {
        logic strobe;
        logic bitVal;
        logic illegal;
        logic carrier;
    } lfw_afe_t;

endpackage

// ---- hdl/lfw_receiver.sv ----
// digital baseband of the low-frequency wake-up receiver
// assumes the front end delivers one strobe per decoded symbol
`include "lfw_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module lfw_receiver #(
    parameter int TICK_CYCLES = `LFW_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic clockEn,
    input wire logic rst_n,
    input wire lfw_pkg::lfw_apb_req_t apbReq,
    output var lfw_pkg::lfw_apb_rsp_t apbRsp,
    input wire lfw_pkg::lfw_afe_t afeIn,
    output logic afePowerEn,
    output logic cpuWake,
    output logic irq
);
    import lfw_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        lfw_state_t st;
        logic [16:0] pre;
        logic [15:0] cnt;
        logic [3:0] bitCnt;
        logic [15:0] shift;
        logic [7:0] words;
        logic [1:0] syncCnt;
        logic [5:0] preCnt;
        logic [7:0] ctrl;
        logic [7:0] onCnt;
        logic [7:0] offH;
        logic [7:0] offL;
        logic [7:0] patH;
        logic [7:0] patL;
        logic [7:0] maxW;
        logic [7:0] rxH;
        logic [7:0] rxL;
        logic [7:0] flags;
        logic [7:0] mask;
        logic wake;
        logic afeOn;
        logic irq;
        lfw_apb_rsp_t rsp;
    } lfw_regs_t;

    lfw_regs_t r_reg;
    lfw_regs_t r_next;
    logic [1:0] rstSync_reg;
    logic rstLocal_n;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // async assert, release through two flops to avoid metastable exit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstLocal_n = rstSync_reg[1];

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // bus, listening timer and telegram decoding share one copy
    always_comb begin
        logic tick;
        logic setup;
        logic done;
        logic [7:0] setFlags;
        logic [7:0] clrFlags;
        logic [31:0] rdata;
        logic mapped;
        logic [15:0] word;
        logic endMsg;
        logic drop;
        tick = 1'b0;
        setup = 1'b0;
        done = 1'b0;
        setFlags = 8'h00;
        clrFlags = 8'h00;
        rdata = 32'h0000_0000;
        mapped = 1'b1;
        word = 16'h0000;
        endMsg = 1'b0;
        drop = 1'b0;
        r_next = r_reg;

        // listening time base
        // free-running tick, so the first off period may be one tick short
        if (r_reg.pre >= 17'(TICK_CYCLES - 1)) begin
            r_next.pre = 17'h0_0000;
            tick = 1'b1;
        end else begin
            r_next.pre = r_reg.pre + 17'h0_0001;
        end

        // duty-cycled search and telegram decoding
        case (r_reg.st)
            ST_IDLE: begin
                // nothing powered until software enables listening
                if (r_reg.ctrl[`LFW_CTRL_LISTEN]) begin
                    r_next.st = ST_OFF;
                    r_next.cnt = 16'h0000;
                end
            end
            ST_OFF: begin
                // front end stays unpowered for the off-time
                if (tick) begin
                    r_next.cnt = r_reg.cnt + 16'h0001;
                end
                if (r_reg.cnt >= {r_reg.offH, r_reg.offL}) begin
                    r_next.st = ST_ON;
                    r_next.cnt = 16'h0000;
                    r_next.preCnt = 6'h00;
                end
            end
            ST_ON: begin
                // window open: count on-time, watch for a preamble
                if (tick) begin
                    r_next.cnt = r_reg.cnt + 16'h0001;
                end
                if (r_reg.ctrl[`LFW_CTRL_CARRIER_MODE]) begin
                    if (afeIn.carrier) begin
                        r_next.wake = 1'b1;
                        setFlags[`LFW_FLAG_WAKE] = 1'b1;
                        r_next.st = ST_OFF;
                        r_next.cnt = 16'h0000;
                    end
                end else if (afeIn.strobe) begin
                    // preamble: run of legal symbols
                    if (afeIn.illegal) begin
                        r_next.preCnt = 6'h00;
                    end else if (r_reg.preCnt + 6'h01 >= `LFW_PREAMBLE_MIN_BITS) begin
                        r_next.st = ST_SYNC;
                        r_next.syncCnt = 2'b00;
                    end else begin
                        r_next.preCnt = r_reg.preCnt + 6'h01;
                    end
                end
                // window closes unless a preamble holds it open
                if (r_next.st == ST_ON && r_reg.cnt >= {8'h00, r_reg.onCnt}) begin
                    r_next.st = ST_OFF;
                    r_next.cnt = 16'h0000;
                end
            end
            ST_SYNC: begin
                // late preamble symbols pass until the first illegal one
                if (afeIn.strobe) begin
                    if (afeIn.illegal) begin
                        r_next.syncCnt = r_reg.syncCnt + 2'b01;
                        if (r_reg.syncCnt + 2'b01 == `LFW_SYNC_SYMBOLS) begin
                            r_next.st = ST_RX;
                            r_next.bitCnt = 4'h0;
                            r_next.words = 8'h00;
                        end
                    end else if (r_reg.syncCnt != 2'b00) begin
                        drop = 1'b1;
                    end
                end
            end
            ST_RX: begin
                if (afeIn.strobe) begin
                    if (afeIn.illegal) begin
                        // only a byte boundary marks a clean end
                        if (r_reg.bitCnt == 4'h0 || r_reg.bitCnt == 4'h8) begin
                            endMsg = 1'b1;
                        end else begin
                            drop = 1'b1;
                        end
                    end else begin
                        word = {r_reg.shift[14:0], afeIn.bitVal};
                        r_next.shift = word;
                        r_next.bitCnt = r_reg.bitCnt + 4'h1;
                        if (r_reg.bitCnt == 4'hf) begin
                            r_next.rxH = word[15:8];
                            r_next.rxL = word[7:0];
                            setFlags[`LFW_FLAG_RX_WORD] = 1'b1;
                            r_next.words = r_reg.words + 8'h01;
                            if (r_reg.words == 8'h00 && r_reg.ctrl[`LFW_CTRL_WAKE_EN]) begin
                                if (word == {r_reg.patH, r_reg.patL}) begin
                                    r_next.wake = 1'b1;
                                    setFlags[`LFW_FLAG_WAKE] = 1'b1;
                                end else begin
                                    drop = 1'b1;
                                end
                            end
                            // wake id word counts against the limit
                            if (r_reg.words + 8'h01 >= r_reg.maxW) begin
                                endMsg = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase

        // leaving a telegram always restarts the off-time count
        if (endMsg || drop) begin
            r_next.st = ST_OFF;
            r_next.cnt = 16'h0000;
            setFlags[`LFW_FLAG_END] = endMsg;
            setFlags[`LFW_FLAG_DISCARD] = drop;
        end
        // software switch-off wins over any decoding step
        if (!r_reg.ctrl[`LFW_CTRL_LISTEN]) begin
            r_next.st = ST_IDLE;
        end

        // apb read mux
        case (apbReq.paddr)
            `LFW_OFS_POWER_CTRL: rdata = {24'h00_0000, 1'b0, r_reg.ctrl[6:0]};
            `LFW_OFS_LISTEN_ON: rdata = {24'h00_0000, r_reg.onCnt};
            `LFW_OFS_LISTEN_OFF_HIGH: rdata = {24'h00_0000, r_reg.offH};
            `LFW_OFS_LISTEN_OFF_LOW: rdata = {24'h00_0000, r_reg.offL};
            `LFW_OFS_WAKE_PAT_HIGH: rdata = {24'h00_0000, r_reg.patH};
            `LFW_OFS_WAKE_PAT_LOW: rdata = {24'h00_0000, r_reg.patL};
            `LFW_OFS_MAX_WORDS: rdata = {24'h00_0000, r_reg.maxW};
            `LFW_OFS_RX_HIGH: rdata = {24'h00_0000, r_reg.rxH};
            `LFW_OFS_RX_LOW: rdata = {24'h00_0000, r_reg.rxL};
            `LFW_OFS_IRQ_FLAGS: rdata = {24'h00_0000, r_reg.flags};
            `LFW_OFS_IRQ_MASK: rdata = {24'h00_0000, r_reg.mask};
            `LFW_OFS_STATE: rdata = {16'h0000, r_reg.words, 3'b000, r_reg.wake, r_reg.afeOn, r_reg.st};
            default: mapped = 1'b0;
        endcase

        // setup cycle prepares the answer, so every access set up with clock enable high completes without a wait
        setup = apbReq.psel && !apbReq.penable;
        done = apbReq.psel && apbReq.penable && r_reg.rsp.pready;
        r_next.rsp.pready = setup;
        if (setup) begin
            r_next.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rdata;
            r_next.rsp.pslverr = !mapped;
        end else if (done) begin
            r_next.rsp.pslverr = 1'b0;
        end

        // writes land only at the completing edge
        if (done && apbReq.pwrite && mapped) begin
            case (apbReq.paddr)
                `LFW_OFS_POWER_CTRL: begin
                    r_next.ctrl = {1'b0, apbReq.pwdata[6:0]};
                    if (apbReq.pwdata[`LFW_CTRL_WAKE_RELEASE]) begin
                        r_next.wake = 1'b0;
                    end
                end
                `LFW_OFS_LISTEN_ON: r_next.onCnt = apbReq.pwdata[7:0];
                `LFW_OFS_LISTEN_OFF_HIGH: r_next.offH = apbReq.pwdata[7:0];
                `LFW_OFS_LISTEN_OFF_LOW: r_next.offL = apbReq.pwdata[7:0];
                `LFW_OFS_WAKE_PAT_HIGH: r_next.patH = apbReq.pwdata[7:0];
                `LFW_OFS_WAKE_PAT_LOW: r_next.patL = apbReq.pwdata[7:0];
                `LFW_OFS_MAX_WORDS: r_next.maxW = apbReq.pwdata[7:0];
                `LFW_OFS_IRQ_MASK: r_next.mask = apbReq.pwdata[7:0];
                default: r_next.rsp.pslverr = 1'b0;
            endcase
        end
        // read clears only the bits software actually saw
        if (done && !apbReq.pwrite && apbReq.paddr == `LFW_OFS_IRQ_FLAGS) begin
            clrFlags = r_reg.rsp.prdata[7:0];
        end
        // a new event beats the clear in the same cycle
        r_next.flags = (r_reg.flags & ~clrFlags) | setFlags;
        r_next.irq = |(r_next.flags & r_next.mask);
        // front end power follows the state about to be entered
        r_next.afeOn = r_next.st == ST_ON || r_next.st == ST_SYNC || r_next.st == ST_RX;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // clock enable low holds every field, the bus answer too
    always_ff @(posedge clock or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.ctrl <= `LFW_RST_CTRL;
            r_reg.onCnt <= `LFW_RST_ON_COUNT;
            r_reg.offH <= 8'(`LFW_RST_OFF_COUNT >> 8);
            r_reg.offL <= 8'(`LFW_RST_OFF_COUNT & 16'h00ff);
            r_reg.maxW <= `LFW_RST_MAX_WORDS;
        end else if (clockEn) begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flops
    // ------------------------------------------------------------
    assign apbRsp = r_reg.rsp;
    assign afePowerEn = r_reg.afeOn;
    assign cpuWake = r_reg.wake;
    assign irq = r_reg.irq;

endmodule // lfw_receiver

`default_nettype wire

// ---- tb/lfw_properties.sv ----
// port assertions of the wake-up telegram receiver
// assumes it is bound to lfw_receiver, one clock domain
`timescale 1ns/1ns
`default_nettype none
module lfw_properties #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clock,
    input wire logic clockEn,
    input wire logic rst_n,
    input wire lfw_pkg::lfw_apb_req_t apbReq,
    input wire lfw_pkg::lfw_apb_rsp_t apbRsp,
    input wire lfw_pkg::lfw_afe_t afeIn,
    input wire logic afePowerEn,
    input wire logic cpuWake,
    input wire logic irq
);
    import lfw_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic doneNow;
    logic relNow;
    // completed transfer, and the write that releases the wake line
    assign doneNow = apbReq.psel & apbReq.penable & apbRsp.pready & clockEn;
    assign relNow = doneNow & apbReq.pwrite & (apbReq.paddr == 12'h000) & apbReq.pwdata[7];
    sequence s_setup;
        apbReq.psel && !apbReq.penable && clockEn;
    endsequence
    sequence s_quiet;
        !afePowerEn && !cpuWake && !irq;
    endsequence
    chk_ready_follows: assert property (s_setup |=> apbRsp.pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (apbRsp.pready |-> $past(apbReq.psel && !apbReq.penable) ##1 !apbRsp.pready)
        else $error("pready not a single answer");
    chk_data_hold: assert property (!apbRsp.pready |=> apbRsp.pready || $stable({apbRsp.pslverr, apbRsp.prdata}))
        else $error("read data moved between answers");
    chk_wake_cause: assert property ($rose(cpuWake) |-> $past(afeIn.strobe) || $past(afeIn.carrier))
        else $error("wake without symbol or carrier");
    chk_wake_sticky: assert property (cpuWake && !relNow |=> cpuWake)
        else $error("wake dropped without release");
    chk_wake_release: assert property (relNow |=> !cpuWake)
        else $error("wake not released");
    chk_irq_cause: assert property ($rose(irq) |-> $past(afeIn.strobe || afeIn.carrier || (doneNow && apbReq.pwrite)))
        else $error("irq rose without event");
    chk_irq_clear: assert property ($fell(irq) |-> $past(doneNow))
        else $error("irq fell without access");
    chk_reset_quiet: assert property ($rose(rst_n) |-> s_quiet ##1 s_quiet)
        else $error("outputs active after reset");
    chk_freeze_hold: assert property (!clockEn |=> $stable({afePowerEn, cpuWake, irq, apbRsp}))
        else $error("outputs moved while frozen");
endmodule // lfw_properties
bind lfw_receiver lfw_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clock(clock), .clockEn(clockEn),
    .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .afeIn(afeIn), .afePowerEn(afePowerEn),
    .cpuWake(cpuWake), .irq(irq));
`default_nettype wire

// ---- tb/lfw_transmitter.sv ----
// base-station transmitter as the front end decodes it
// assumes callers enter its tasks just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module lfw_transmitter #(
    parameter int GAP = 8,
    parameter int PRE = 8
) (
    input wire logic clock,
    output var lfw_pkg::lfw_afe_t afeOut
);
    import lfw_pkg::*;
    initial afeOut = '0;
    // one symbol per bit time; stale bits inverted between strobes
    task automatic symbol(input logic b, input logic bad);
        afeOut.strobe <= 1'b1;
        afeOut.bitVal <= b;
        afeOut.illegal <= bad;
        @(posedge clock);
        afeOut.strobe <= 1'b0;
        afeOut.bitVal <= ~b;
        afeOut.illegal <= ~bad;
        repeat (GAP - 1) @(posedge clock);
    endtask
    // word sent msb first
    task automatic word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) symbol(w[i], 1'b0);
    endtask
    // preamble long enough to settle, sync of two illegal symbols, id
    task automatic telegram(input logic [15:0] id);
        for (int i = 0; i < PRE; i++) symbol(i[0], 1'b0);
        repeat (2) symbol(1'b0, 1'b1);
        word(id);
    endtask
    task automatic carrier(input logic on);
        afeOut.carrier <= on;
    endtask
endmodule // lfw_transmitter
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the wake-up telegram receiver
// assumes the transmitter model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import lfw_pkg::*;
    logic clock, rst_n, afeOn, wake, irq;
    logic clockEn;
    lfw_apb_req_t req;
    lfw_apb_rsp_t rsp;
    lfw_afe_t afe;
    int miscompares = 0;
    int checkCount = 0;
    lfw_receiver #(.TICK_CYCLES(4)) dut_u (.clock(clock), .clockEn(clockEn), .rst_n(rst_n), .apbReq(req),
        .apbRsp(rsp), .afeIn(afe), .afePowerEn(afeOn), .cpuWake(wake), .irq(irq));
    lfw_transmitter tx_u (.clock(clock), .afeOut(afe));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, idle cycle after so strobes never collide
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clock);
        req.penable <= 1'b1;
        // no cap here: only the watchdog ends a wait
        do begin
            @(posedge clock);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h0, d}, q, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] x, input string what);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(what, q, {24'h0, x});
    endtask
    // program pattern a5c3, long window, then wait for it to open
    task automatic arm(input logic [7:0] ctrl, input logic [7:0] words);
        int n = 0;
        wr(12'h004, 8'hff);
        wr(12'h010, 8'ha5);
        wr(12'h014, 8'hc3);
        wr(12'h018, words);
        wr(12'h028, 8'h27);
        wr(12'h000, ctrl);
        while (afeOn !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        check("window", afeOn, 1'b1);
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rdchk(12'h000, 8'h00, "ctrl");
        rdchk(12'h004, 8'h04, "on count");
        rdchk(12'h008, 8'h00, "off high");
        rdchk(12'h00c, 8'h10, "off low");
        rdchk(12'h018, 8'h04, "max words");
        wr(12'h01c, 8'hff);
        rdchk(12'h01c, 8'h00, "rx high ro");
        apb(1'b0, 12'h030, 32'h0, q, e);
        check("unmapped", e, 1'b1);
    endtask
    task automatic t_match();
        arm(8'h11, 8'h02);
        tx_u.telegram(16'ha5c3);
        check("wake", wake, 1'b1);
        check("irq", irq, 1'b1);
        rdchk(12'h01c, 8'ha5, "id high");
        rdchk(12'h020, 8'hc3, "id low");
        rdchk(12'h024, 8'h21, "id flags");
        check("irq clear", irq, 1'b0);
        tx_u.word(16'h1234);
        check("end power", afeOn, 1'b0);
        rdchk(12'h020, 8'h34, "data low");
        rdchk(12'h024, 8'h22, "end flags");
        wr(12'h000, 8'h80);
        check("released", wake, 1'b0);
    endtask
    task automatic t_mismatch();
        arm(8'h11, 8'h04);
        tx_u.telegram(16'h0000);
        check("no wake", wake, 1'b0);
        check("discard power", afeOn, 1'b0);
        rdchk(12'h024, 8'h24, "mismatch flags");
    endtask
    task automatic t_sync();
        arm(8'h11, 8'h04);
        repeat (8) tx_u.symbol(1'b1, 1'b0);
        tx_u.symbol(1'b0, 1'b1);
        repeat (4) tx_u.symbol(1'b1, 1'b0);
        check("sync wake", wake, 1'b0);
        rdchk(12'h024, 8'h04, "sync flags");
    endtask
    task automatic t_boundary();
        arm(8'h11, 8'h04);
        tx_u.telegram(16'ha5c3);
        repeat (8) tx_u.symbol(1'b1, 1'b0);
        tx_u.symbol(1'b0, 1'b1);
        check("boundary power", afeOn, 1'b0);
        rdchk(12'h024, 8'h23, "boundary flags");
        wr(12'h000, 8'h80);
    endtask
    task automatic t_carrier();
        arm(8'h03, 8'h04);
        wr(12'h028, 8'h00);
        tx_u.carrier(1'b1);
        repeat (3) @(posedge clock);
        tx_u.carrier(1'b0);
        check("carrier wake", wake, 1'b1);
        check("masked irq", irq, 1'b0);
        wr(12'h028, 8'h01);
        check("unmasked irq", irq, 1'b1);
        rdchk(12'h024, 8'h01, "carrier flags");
        wr(12'h000, 8'h80);
    endtask
    // frozen clock enable ignores a telegram; then id check off, limit 0
    task automatic t_freeze();
        logic [31:0] q;
        logic e;
        arm(8'h01, 8'h00);
        clockEn <= 1'b0;
        tx_u.telegram(16'ha5c3);
        check("frozen power", afeOn, 1'b1);
        check("frozen wake", wake, 1'b0);
        clockEn <= 1'b1;
        tx_u.telegram(16'h0f0f);
        check("plain wake", wake, 1'b0);
        check("plain power", afeOn, 1'b0);
        check("plain irq", irq, 1'b1);
        rdchk(12'h020, 8'h0f, "plain low");
        rdchk(12'h024, 8'h22, "plain flags");
        apb(1'b0, 12'h02c, 32'h0, q, e);
        check("state", q, 32'h0000_0101);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        clockEn = 1'b1;
        req = '0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset();
        t_match();
        t_mismatch();
        t_sync();
        t_boundary();
        t_carrier();
        t_freeze();
        finish_test();
    end
    // watchdog, about twenty times the expected run
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        finish_test();
    end
endmodule // testbench
`default_nettype wire
